/* include/etc_pkg.sv */
// package of constants and carrier types for the excitation timer control
package etc_pkg;
   // ***************************
   // register map (byte offsets)
   // ***************************
   localparam logic [7:0] CTRL_OFFSET = 8'h6C;
   localparam logic [7:0] CAPT_OFFSET = 8'h70;
   localparam logic [7:0] RELOAD_OFFSET = 8'h74;
   localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h80;
   localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h84;
   localparam logic [7:0] IRQ_CLEAR_OFFSET = 8'h88;
   // *****************************
   // control register field layout
   // *****************************
   localparam int ZC_SEL_LSB = 30;
   localparam int SRC_SEL_BIT = 28;
   localparam int SOFT_TRIG_BIT = 24;
   localparam int CMP_EN_BIT = 21;
   localparam int IRQ_EN_BIT = 20;
   localparam int DMA_EN_BIT = 19;
   localparam int ADC_EN_BIT = 18;
   localparam int EDGE_SEL_BIT = 17;
   localparam int RUN_BIT = 16;
   localparam int CNT_W = 16;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [15:0] CNT_RESET = 16'h0000;
   localparam logic [15:0] RELOAD_RESET = 16'h0002;
   // pulse select codes
   localparam logic [1:0] ZC_BOTH = 2'h0;
   localparam logic [1:0] ZC_RISE = 2'h1;
   localparam logic [1:0] ZC_FALL = 2'h2;
   localparam logic [1:0] ZC_NONE = 2'h3;
   // sticky event bit positions
   localparam int EV_ZC = 0;
   localparam int EV_CMP = 1;
   localparam int EV_RELOAD = 2;
   localparam int EV_W = 3;

   // control fields
   typedef struct packed {
      logic [1:0] zc_pulse_select;
      logic timer_zc_source_select;
      logic compare_enable;
      logic irq_enable;
      logic dma_req_enable;
      logic adc_trigger_enable;
      logic zc_edge_select;
      logic counter_run;
   } etc_ctrl_type;

   // APB answer group
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } etc_apb_rsp_type;

   // state of the block apart from the pin synchronisers
   typedef struct packed {
      etc_ctrl_type ctrl;
      logic [15:0] reload;
      logic [15:0] capture;
      logic [15:0] counter;
      logic [15:0] period;
      logic zc_prev;
      logic soft_pend;
      logic cmp_hit;
      logic [EV_W-1:0] status;
      logic [EV_W-1:0] irq_mask;
      etc_apb_rsp_type rsp;
      logic zc_pulse;
      logic et_zc;
      logic irq;
      logic dma_req;
      logic adc_trig;
      logic sum_irq;
   } etc_state_type;
endpackage : etc_pkg

/* core/etc_top.sv */
// excitation timer control and status block with APB register access
`timescale 1ns/1ps
`default_nettype none
module etc_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic zc_input,
   input wire logic zc_extracted,
   input wire logic [15:0] compare_value,
   output logic zc_pulse,
   output logic et_zc,
   output logic et_irq,
   output logic et_dma_req,
   output logic et_adc_trig,
   output logic irq
);
   etc_pkg::etc_state_type s_q, s_d;
   logic [1:0] zin_sync_q, zext_sync_q;
   logic zc_sel, zc_rise, zc_fall, et_edge, acc, wr, rd, cmp_match;
   logic [31:0] ctrl_word;

   // byte-lane merge for APB writes
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // ****************************
   // pin synchronisers
   // ****************************
   // zc inputs come from analogue front end, so two flops each
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         zin_sync_q <= 2'h0;
         zext_sync_q <= 2'h0;
      end else begin
         zin_sync_q <= {zin_sync_q[0], zc_input};
         zext_sync_q <= {zext_sync_q[0], zc_extracted};
      end
   end

   // ****************************
   // control word view
   // ****************************
   // reserved and trigger bits are left zero on read
   always_comb begin
      ctrl_word = etc_pkg::CTRL_RESET;
      ctrl_word[etc_pkg::ZC_SEL_LSB +: 2] = s_q.ctrl.zc_pulse_select;
      ctrl_word[etc_pkg::SRC_SEL_BIT] = s_q.ctrl.timer_zc_source_select;
      ctrl_word[etc_pkg::SOFT_TRIG_BIT] = 1'b0;
      ctrl_word[etc_pkg::CMP_EN_BIT] = s_q.ctrl.compare_enable;
      ctrl_word[etc_pkg::IRQ_EN_BIT] = s_q.ctrl.irq_enable;
      ctrl_word[etc_pkg::DMA_EN_BIT] = s_q.ctrl.dma_req_enable;
      ctrl_word[etc_pkg::ADC_EN_BIT] = s_q.ctrl.adc_trigger_enable;
      ctrl_word[etc_pkg::EDGE_SEL_BIT] = s_q.ctrl.zc_edge_select;
      ctrl_word[etc_pkg::RUN_BIT] = s_q.ctrl.counter_run;
      ctrl_word[etc_pkg::CNT_W-1:0] = s_q.counter;
   end

   // ****************************
   // edge decode
   // ****************************
   // extracted source may jitter while tracking; no period filter here
   assign zc_sel = s_q.ctrl.timer_zc_source_select ? zext_sync_q[1]
                   : zin_sync_q[1];
   assign zc_rise = zc_sel & ~s_q.zc_prev;
   assign zc_fall = ~zc_sel & s_q.zc_prev;
   assign et_edge = s_q.ctrl.zc_edge_select ? zc_fall : zc_rise;
   assign acc = psel & penable;
   assign wr = acc & pwrite;
   assign rd = acc & ~pwrite;
   assign cmp_match = s_q.ctrl.compare_enable & s_q.ctrl.counter_run
                      & (s_q.period == compare_value);

   // ****************************
   // next-state logic
   // ****************************
   always_comb begin
      logic [31:0] m;
      logic [etc_pkg::EV_W-1:0] ev;
      m = 32'h0000_0000;
      ev = '0;
      s_d = s_q;
      s_d.zc_prev = zc_sel;
      s_d.soft_pend = 1'b0;
      // pulse shaping, one core clock wide
      case (s_q.ctrl.zc_pulse_select)
         etc_pkg::ZC_BOTH: s_d.zc_pulse = zc_rise | zc_fall;
         etc_pkg::ZC_RISE: s_d.zc_pulse = zc_rise;
         etc_pkg::ZC_FALL: s_d.zc_pulse = zc_fall;
         etc_pkg::ZC_NONE: s_d.zc_pulse = 1'b0;
         default: s_d.zc_pulse = 1'b0;
      endcase
      // timers: run high counts, run low parks the event timer on reload and holds the period
      if (s_q.ctrl.counter_run) begin
         s_d.counter = (s_q.counter == 16'h0000) ? s_q.reload
                       : 16'(s_q.counter - 16'h0001);
         s_d.period = 16'(s_q.period + 16'h0001);
         if (cmp_match) begin
            s_d.capture = s_q.period;
            s_d.period = 16'h0000;
         end else if (et_edge) begin
            s_d.capture = s_q.period;
            s_d.period = 16'h0000;
         end
      end else begin
         s_d.counter = s_q.reload;
      end
      s_d.cmp_hit = cmp_match;
      // outputs: soft trigger joins the timer zc strobe
      s_d.et_zc = (s_q.ctrl.counter_run & et_edge) | s_q.soft_pend;
      s_d.irq = s_q.cmp_hit & s_q.ctrl.irq_enable;
      s_d.dma_req = s_q.cmp_hit & s_q.ctrl.dma_req_enable;
      s_d.adc_trig = s_q.et_zc & s_q.ctrl.adc_trigger_enable;
      ev[etc_pkg::EV_ZC] = s_q.zc_pulse;
      ev[etc_pkg::EV_CMP] = s_q.cmp_hit;
      ev[etc_pkg::EV_RELOAD] = s_q.ctrl.counter_run
                               & (s_q.counter == 16'h0000);
      // APB: one wait state, answer registered in the cycle after the first access cycle
      s_d.rsp.pready = acc & ~s_q.rsp.pready;
      s_d.rsp.pslverr = 1'b0;
      s_d.rsp.prdata = 32'h0000_0000;
      if (wr & ~s_q.rsp.pready) begin
         case (paddr)
            etc_pkg::CTRL_OFFSET: begin
               m = merge(ctrl_word, pwdata, pstrb);
               s_d.ctrl.zc_pulse_select = m[etc_pkg::ZC_SEL_LSB +: 2];
               s_d.ctrl.timer_zc_source_select = m[etc_pkg::SRC_SEL_BIT];
               s_d.ctrl.compare_enable = m[etc_pkg::CMP_EN_BIT];
               s_d.ctrl.irq_enable = m[etc_pkg::IRQ_EN_BIT];
               s_d.ctrl.dma_req_enable = m[etc_pkg::DMA_EN_BIT];
               s_d.ctrl.adc_trigger_enable = m[etc_pkg::ADC_EN_BIT];
               s_d.ctrl.zc_edge_select = m[etc_pkg::EDGE_SEL_BIT];
               s_d.ctrl.counter_run = m[etc_pkg::RUN_BIT];
               s_d.soft_pend = pstrb[3]
                               & pwdata[etc_pkg::SOFT_TRIG_BIT];
            end
            etc_pkg::RELOAD_OFFSET: begin
               m = merge({16'h0000, s_q.reload}, pwdata, pstrb);
               s_d.reload = m[15:0];
            end
            etc_pkg::IRQ_ENABLE_OFFSET: begin
               m = merge({29'h0, s_q.irq_mask}, pwdata, pstrb);
               s_d.irq_mask = m[etc_pkg::EV_W-1:0];
            end
            etc_pkg::IRQ_CLEAR_OFFSET: begin
               if (pstrb[0]) begin
                  s_d.status = s_q.status & ~pwdata[etc_pkg::EV_W-1:0];
               end
            end
            etc_pkg::CAPT_OFFSET, etc_pkg::IRQ_STATUS_OFFSET: ;
            default: s_d.rsp.pslverr = 1'b1;
         endcase
      end else if (rd & ~s_q.rsp.pready) begin
         case (paddr)
            etc_pkg::CTRL_OFFSET: s_d.rsp.prdata = ctrl_word;
            etc_pkg::CAPT_OFFSET:
               s_d.rsp.prdata = {s_q.capture, compare_value};
            etc_pkg::RELOAD_OFFSET:
               s_d.rsp.prdata = {s_q.period, s_q.reload};
            etc_pkg::IRQ_STATUS_OFFSET:
               s_d.rsp.prdata = {29'h0, s_q.status};
            etc_pkg::IRQ_ENABLE_OFFSET:
               s_d.rsp.prdata = {29'h0, s_q.irq_mask};
            etc_pkg::IRQ_CLEAR_OFFSET: s_d.rsp.prdata = 32'h0000_0000;
            default: s_d.rsp.pslverr = 1'b1;
         endcase
      end
      // set wins over a clear in the same cycle
      s_d.status = s_d.status | ev;
      s_d.sum_irq = |(s_d.status & s_q.irq_mask);
   end

   // ****************************
   // state register
   // ****************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
         s_q.reload <= etc_pkg::RELOAD_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.rsp.prdata;
   assign pready = s_q.rsp.pready;
   assign pslverr = s_q.rsp.pslverr;
   assign zc_pulse = s_q.zc_pulse;
   assign et_zc = s_q.et_zc;
   assign et_irq = s_q.irq;
   assign et_dma_req = s_q.dma_req;
   assign et_adc_trig = s_q.adc_trig;
   assign irq = s_q.sum_irq;

   // ****************************
   // assertions
   // ****************************
   // pulse shaping follows the select code of the cycle before
   a_zc_none_quiet: assert property (
      @(posedge pclk) disable iff (!presetn)
      $past(s_q.ctrl.zc_pulse_select) == etc_pkg::ZC_NONE |-> !zc_pulse)
      else $error("zc pulse while suppressed");
   a_zc_pulse_single: assert property (
      @(posedge pclk) disable iff (!presetn)
      zc_pulse |=> !zc_pulse)
      else $error("zc pulse wider than one cycle");
   a_zc_rise_only: assert property (
      @(posedge pclk) disable iff (!presetn)
      $past(s_q.ctrl.zc_pulse_select) == etc_pkg::ZC_RISE && zc_pulse
      |-> $past(zc_rise))
      else $error("zc pulse without a rising edge");
   a_zc_fall_only: assert property (
      @(posedge pclk) disable iff (!presetn)
      $past(s_q.ctrl.zc_pulse_select) == etc_pkg::ZC_FALL && zc_pulse
      |-> $past(zc_fall))
      else $error("zc pulse without a falling edge");
   a_zc_both_edges: assert property (
      @(posedge pclk) disable iff (!presetn)
      $past(s_q.ctrl.zc_pulse_select) == etc_pkg::ZC_BOTH
      && $past(zc_rise || zc_fall) |-> zc_pulse)
      else $error("zc edge without pulse");

   // source select: the edge detector follows the chosen pin
   a_src_extracted: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_q.ctrl.timer_zc_source_select
      |=> s_q.zc_prev == $past(zext_sync_q[1]))
      else $error("extracted source not followed");
   a_src_input: assert property (
      @(posedge pclk) disable iff (!presetn)
      !s_q.ctrl.timer_zc_source_select
      |=> s_q.zc_prev == $past(zin_sync_q[1]))
      else $error("input source not followed");
   a_edge_strobe: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_q.ctrl.counter_run && et_edge |=> et_zc)
      else $error("selected edge gave no strobe");
   a_et_zc_cause: assert property (
      @(posedge pclk) disable iff (!presetn)
      et_zc |-> $past(s_q.soft_pend)
      || $past(s_q.ctrl.counter_run && et_edge))
      else $error("timer strobe without cause");
   a_soft_pulse: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_q.soft_pend |=> et_zc ##1 (!et_zc || $past(s_q.soft_pend)
      || $past(et_edge)))
      else $error("soft trigger pulse wrong");

   // timers: stop freezes and reloads, run counts
   a_stop_reload: assert property (
      @(posedge pclk) disable iff (!presetn)
      !s_q.ctrl.counter_run ##1 !s_q.ctrl.counter_run
      |-> s_q.counter == $past(s_q.reload))
      else $error("stopped counter not reloaded");
   a_halt_period: assert property (
      @(posedge pclk) disable iff (!presetn)
      !s_q.ctrl.counter_run |=> s_q.period == $past(s_q.period))
      else $error("period timer moved while stopped");
   a_run_count: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_q.ctrl.counter_run && !cmp_match && !et_edge
      |=> s_q.period == 16'($past(s_q.period) + 16'h0001))
      else $error("period timer not counting");
   a_run_down: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_q.ctrl.counter_run && s_q.counter != 16'h0000
      |=> s_q.counter == 16'($past(s_q.counter) - 16'h0001))
      else $error("event timer not counting");

   // compare match and the gated requests
   a_cmp_off: assert property (
      @(posedge pclk) disable iff (!presetn)
      $past(!s_q.ctrl.compare_enable) |-> !s_q.cmp_hit)
      else $error("compare match while disabled");
   a_match_clear: assert property (
      @(posedge pclk) disable iff (!presetn)
      cmp_match |=> s_q.period == 16'h0000
      ##1 s_q.irq == $past(s_q.ctrl.irq_enable))
      else $error("compare match handling wrong");
   a_cmp_capture: assert property (
      @(posedge pclk) disable iff (!presetn)
      cmp_match |=> s_q.capture == $past(s_q.period))
      else $error("compare match not captured");
   a_irq_gate: assert property (
      @(posedge pclk) disable iff (!presetn)
      et_irq |-> $past(s_q.ctrl.irq_enable) && $past(s_q.cmp_hit))
      else $error("irq without enable");
   a_dma_gate: assert property (
      @(posedge pclk) disable iff (!presetn)
      et_dma_req |-> $past(s_q.ctrl.dma_req_enable))
      else $error("dma request without enable");
   a_dma_timing: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_q.cmp_hit && s_q.ctrl.dma_req_enable |=> et_dma_req)
      else $error("enabled dma request missing");
   a_adc_gate: assert property (
      @(posedge pclk) disable iff (!presetn)
      et_adc_trig |-> $past(s_q.ctrl.adc_trigger_enable))
      else $error("adc trigger without enable");
   a_adc_timing: assert property (
      @(posedge pclk) disable iff (!presetn)
      et_zc && s_q.ctrl.adc_trigger_enable |=> et_adc_trig)
      else $error("enabled adc trigger missing");

   // register view and bus answer, checked on what leaves the block
   a_trig_reads0: assert property (
      @(posedge pclk) disable iff (!presetn)
      pready && $past(!pwrite) && $past(paddr) == etc_pkg::CTRL_OFFSET
      |-> !prdata[etc_pkg::SOFT_TRIG_BIT])
      else $error("trigger bit read nonzero");
   a_resv_read0: assert property (
      @(posedge pclk) disable iff (!presetn)
      pready && $past(!pwrite) && $past(paddr) == etc_pkg::CTRL_OFFSET
      |-> (prdata & 32'h2EC0_0000) == 32'h0000_0000)
      else $error("reserved bits read nonzero");
   a_cnt_read: assert property (
      @(posedge pclk) disable iff (!presetn)
      pready && $past(!pwrite) && $past(paddr) == etc_pkg::CTRL_OFFSET
      |-> prdata[etc_pkg::CNT_W-1:0] == $past(s_q.counter))
      else $error("counter field not live");
   a_ready_single: assert property (
      @(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
      else $error("pready held for two cycles");
   a_err_pair: assert property (
      @(posedge pclk) disable iff (!presetn)
      pslverr |-> pready)
      else $error("pslverr without pready");
   a_irq_level: assert property (
      @(posedge pclk) disable iff (!presetn)
      irq == |(s_q.status & $past(s_q.irq_mask)))
      else $error("summary irq level wrong");

   // main scenarios
   c_match: cover property (@(posedge pclk) cmp_match ##2 et_irq);
   c_soft: cover property (@(posedge pclk) s_q.soft_pend ##1 et_zc);
   c_fall: cover property (@(posedge pclk) zc_fall ##1 zc_pulse);
   c_dma: cover property (@(posedge pclk) et_dma_req);
   c_clear: cover property (@(posedge pclk)
      wr && paddr == etc_pkg::IRQ_CLEAR_OFFSET);
endmodule : etc_top
`default_nettype wire

/* dv/etc_far_model.sv */
// far-side model: counts pulses on the zc pulse, timer zc, irq, dma and adc trigger outputs
`timescale 1ns/1ps
`default_nettype none
module etc_far_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [4:0] ev,
   output logic [4:0][7:0] cnt
);
   // ***********
   // pulse count
   // ***********
   // every high cycle counts, so a stretched pulse shows as extra events
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= '0;
      end else begin
         for (int i = 0; i < 5; i++) begin
            cnt[i] <= cnt[i] + 8'(ev[i]);
         end
      end
   end
endmodule : etc_far_model
`default_nettype wire

/* dv/test_excitation_timer_control.sv */
// testbench of the excitation timer control block
`timescale 1ns/1ps
`default_nettype none
module test_excitation_timer_control;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
   logic zi, zx, zc_pulse, et_zc, et_irq, et_dma, et_adc, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [15:0] cv;
   logic [3:0] strb;
   logic [4:0][7:0] cnt, snap;
   int n_errors, cmp_count;
   // *********
   // instances
   // *********
   etc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(strb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .zc_input(zi), .zc_extracted(zx), .compare_value(cv),
      .zc_pulse(zc_pulse), .et_zc(et_zc), .et_irq(et_irq),
      .et_dma_req(et_dma), .et_adc_trig(et_adc), .irq(irq));
   etc_far_model far (.pclk(pclk), .presetn(presetn),
      .ev({et_adc, et_dma, et_irq, et_zc, zc_pulse}), .cnt(cnt));
   // *****
   // tasks
   // *****
   // one apb transfer; an idle edge first keeps each signal to one update
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int t;
      t = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         t++;
      end while (pready !== 1'b1 && t < 20);
      if (t >= 20) n_errors++;
      rdat = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : chk
   // pulses seen on one output since the last look
   task automatic dchk(input int i, input logic [7:0] e);
      chk(32'(cnt[i] - snap[i]), 32'(e));
      snap[i] = cnt[i];
   endtask : dchk
   task automatic nz(input int i);
      chk(32'(cnt[i] != snap[i]), 32'h1);
      snap[i] = cnt[i];
   endtask : nz
   // sync plus edge detect needs about four cycles, eight leaves margin
   task automatic tog(input logic s, input logic v);
      if (s) zx <= v;
      else zi <= v;
      cyc(8);
   endtask : tog
   task automatic finish_test;
      $display("errors %0d comparisons %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : finish_test
   // ***********
   // clock, runs
   // ***********
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      n_errors++;
      finish_test();
   end
   initial begin
      {presetn, psel, penable, pwrite, zi, zx} = '0;
      paddr = '0;
      pwdata = '0;
      cv = 16'h0010;
      strb = 4'hF;
      snap = '0;
      n_errors = 0;
      cmp_count = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, etc_pkg::CTRL_OFFSET, 0);
      chk(rdat, 32'h0000_0002);
      apb(1, etc_pkg::RELOAD_OFFSET, 32'h0000_0005);
      apb(1, etc_pkg::CTRL_OFFSET, 32'hD03E_0000);
      apb(0, etc_pkg::CTRL_OFFSET, 0);
      chk(rdat, 32'hD03E_0005);
      // every pulse select code, rising then falling input edge
      for (int c = 0; c < 4; c++) begin
         apb(1, etc_pkg::CTRL_OFFSET, {c[1:0], 30'h0});
         tog(1'b0, 1'b1);
         dchk(0, 8'(!c[1]));
         tog(1'b0, 1'b0);
         dchk(0, 8'(!c[0]));
      end
      // timer source and edge select while running
      for (int s = 0; s < 2; s++) begin
         for (int e = 0; e < 2; e++) begin
            apb(1, etc_pkg::CTRL_OFFSET,
                {3'h0, s[0], 10'h0, e[0], 1'b1, 16'h0});
            tog(!s[0], 1'b1);
            tog(!s[0], 1'b0);
            dchk(1, 0);
            tog(s[0], 1'b1);
            dchk(1, 8'(!e[0]));
            tog(s[0], 1'b0);
            dchk(1, 8'(e[0]));
         end
      end
      apb(1, etc_pkg::CTRL_OFFSET, 0);
      tog(1'b0, 1'b1);
      tog(1'b0, 1'b0);
      dchk(1, 0);
      snap = cnt;
      apb(1, etc_pkg::CTRL_OFFSET, 32'h0104_0000);
      cyc(4);
      dchk(1, 1);
      dchk(4, 1);
      apb(0, etc_pkg::CTRL_OFFSET, 0);
      chk(rdat, 32'h0004_0005);
      apb(1, etc_pkg::CTRL_OFFSET, 32'h0100_0000);
      cyc(4);
      dchk(1, 1);
      dchk(4, 0);
      apb(1, etc_pkg::CTRL_OFFSET, 0);
      cyc(4);
      dchk(1, 0);
      // trigger written without its byte lane does nothing
      strb <= 4'h7;
      apb(1, etc_pkg::CTRL_OFFSET, 32'h0100_0000);
      cyc(4);
      dchk(1, 0);
      strb <= 4'hF;
      // compare match with dma only, then irq only, then compare off
      apb(1, etc_pkg::IRQ_ENABLE_OFFSET, 32'h2);
      snap = cnt;
      apb(1, etc_pkg::CTRL_OFFSET, 32'h0029_0000);
      cyc(60);
      dchk(2, 0);
      nz(3);
      chk(irq, 1'b1);
      apb(0, etc_pkg::CAPT_OFFSET, 0);
      chk({rdat[31:16], 16'h0}, 32'h0010_0000);
      apb(1, etc_pkg::IRQ_ENABLE_OFFSET, 0);
      cyc(2);
      chk(irq, 1'b0);
      apb(1, etc_pkg::IRQ_ENABLE_OFFSET, 32'h2);
      cyc(2);
      chk(irq, 1'b1);
      apb(1, etc_pkg::CTRL_OFFSET, 32'h0031_0000);
      snap = cnt;
      cyc(60);
      nz(2);
      dchk(3, 0);
      apb(1, etc_pkg::CTRL_OFFSET, 32'h0011_0000);
      cyc(4);
      apb(1, etc_pkg::IRQ_CLEAR_OFFSET, 32'h2);
      snap = cnt;
      cyc(60);
      dchk(2, 0);
      chk(irq, 1'b0);
      apb(0, etc_pkg::IRQ_STATUS_OFFSET, 0);
      chk(rdat & 32'h2, 32'h0);
      apb(0, etc_pkg::IRQ_CLEAR_OFFSET, 0);
      chk(rdat, 32'h0);
      // unmapped place is refused
      apb(0, 8'hF0, 0);
      chk({serr, rdat}, {1'b1, 32'h0});
      finish_test();
   end
endmodule : test_excitation_timer_control
`default_nettype wire
